// [pkg/diag_cfg.svh]
// offsets, field positions, reset values and timing counts of the diagnostics block
`ifndef DIAG_CFG_SVH
`define DIAG_CFG_SVH

`define CLK_MHZ 200
`define RECHECK_TIME_US 1000
`define RECHECK_CYC (`RECHECK_TIME_US * `CLK_MHZ)
`define DIAG_CYCLE_TIME_US 100000
`define DIAG_CYCLE_CYC (`DIAG_CYCLE_TIME_US * `CLK_MHZ)
`define AC_PULSES_MIN 2'd3
`define CNT_W 25
`define NUM_CH 4

`define OFS_CTRL_ONE 8'h00
`define OFS_CTRL_TWO 8'h04
`define OFS_RESULT 8'h08
`define OFS_STATUS 8'h0C

`define CTRL_ONE_RST 32'h0000_0000
`define CTRL_TWO_RST 32'h0000_0000
`define C1_STBY_OUT 0
`define C1_DIAG_EN 4
`define C1_OFFSET_EN 5
`define C2_LOW_GAIN 0
`define C2_LINE_DIAG 1
`define C2_AC_EN 2
`define C2_AC_LOW_THR 7

`endif

// [pkg/diag_pkg.sv]
// types shared by the output fault diagnostics block
package diag_pkg;

    // analog comparator flags of one output channel
    typedef struct packed {
        logic gnd_short;
        logic vs_short;
        logic load_short_spk;
        logic load_open_spk;
        logic load_short_line;
        logic load_open_line;
        logic sc_prot;
        logic offset_high;
        logic ac_pk_hi;
        logic ac_pk_lo;
    } ch_sense_type;

    // fault classification of one channel
    typedef struct packed {
        logic gnd;
        logic vs;
        logic across;
        logic open;
    } fault_type;

    // one byte of the result word
    typedef struct packed {
        logic spare;
        logic diag_done;
        logic tweeter_open;
        logic offset_high;
        fault_type fault;
    } result_type;

    typedef enum logic [3:0] {
        CH_ACTIVE = 4'b0001,
        CH_CHECK = 4'b0010,
        CH_DIAG = 4'b0100,
        CH_SHUT = 4'b1000
    } ch_state_type;

    typedef enum logic [2:0] {
        TON_STBY = 3'b001,
        TON_PULSE = 3'b010,
        TON_BIASED = 3'b100
    } ton_state_type;

endpackage : diag_pkg

// [verilog/amp_output_fault_diagnostics.sv]
// output fault diagnostics sequencer for a four-channel amplifier, apb register slave
// Function
// - turn-on test classifies gnd, vs, load, open
// - turn-on result held until next requested pulse, cleared when a permanent diagnostic finds a fault
// - combined write runs pulse first, stage off
// - biased: permanent takes over, keep result
// - capture status at end of 100 ms plateau
// - gnd/vs classification independent of gain
// - line thresholds when low gain and line bit
// - permanent reports shorts and offset, never open
// - diag off: shut faulted channel, recheck 1 ms
// - diag on: protection event triggers diagnostic
// - recheck after 1 ms, then 100 ms cycle
// - after cycle restart mode, next needs read
// - flag offset beyond two volts either polarity
// - offset window from last read or enable
// - offset must persist; protection suspends test
// - ac test enable bit, protection suspends it
// - control two bit 7 selects ac threshold
// - fewer than three pulses means open tweeter
// - multiple faults reported over successive reads
// - supply shorts beat load faults, both reported
// - read restarts cycles, returns previous results
`timescale 1ns/1ps
`default_nettype none
`include "diag_cfg.svh"

module amp_output_fault_diagnostics
    import diag_pkg::*;
#(
    parameter int RECHECK_CYC = `RECHECK_CYC,
    parameter int DIAG_CYCLE_CYC = `DIAG_CYCLE_CYC
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ch_sense_type [`NUM_CH-1:0] sense,
    output logic [`NUM_CH-1:0] stage_on,
    output logic stage_hiz,
    output logic test_pulse_on
);

    localparam logic [`CNT_W-1:0] RECHECK_LAST = `CNT_W'(RECHECK_CYC - 1);
    localparam logic [`CNT_W-1:0] DIAG_LAST = `CNT_W'(DIAG_CYCLE_CYC - 1);

    // apb slave
    logic [31:0] ctrl_one_q;
    logic [31:0] ctrl_two_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] report_q;

    wire hit_one = (paddr == `OFS_CTRL_ONE);
    wire hit_two = (paddr == `OFS_CTRL_TWO);
    wire hit_res = (paddr == `OFS_RESULT);
    wire hit_sta = (paddr == `OFS_STATUS);
    wire mapped = hit_one | hit_two | hit_res | hit_sta;
    wire done = psel & penable & pready_q;
    wire wr_one = done & pwrite & hit_one;
    wire wr_two = done & pwrite & hit_two;
    wire host_read = done & ~pwrite & hit_res;

    wire stby_out = ctrl_one_q[`C1_STBY_OUT];
    wire diag_en = ctrl_one_q[`C1_DIAG_EN];
    wire offset_en = ctrl_one_q[`C1_OFFSET_EN];
    wire line_mode = ctrl_two_q[`C2_LOW_GAIN] & ctrl_two_q[`C2_LINE_DIAG];
    wire ac_en = ctrl_two_q[`C2_AC_EN];
    wire ac_low_thr = ctrl_two_q[`C2_AC_LOW_THR];

    wire stby_rise = wr_one & ~stby_out & pwdata[`C1_STBY_OUT];
    wire offset_rise = wr_one & ~offset_en & pwdata[`C1_OFFSET_EN];
    wire ac_rise = wr_two & ~ac_en & pwdata[`C2_AC_EN];

    logic [31:0] status_w;
    wire [31:0] rd_mux = hit_one ? ctrl_one_q :
                         hit_two ? ctrl_two_q :
                         hit_res ? report_q :
                         hit_sta ? status_w : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            ctrl_one_q <= `CTRL_ONE_RST;
            ctrl_two_q <= `CTRL_TWO_RST;
        end
        else
        begin
            pready_q <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~mapped;
            if (psel & penable & ~pready_q)
                prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
            if (wr_one)
                ctrl_one_q <= pwdata;
            if (wr_two)
                ctrl_two_q <= pwdata;
        end
    end

    // two-stage synchronisers for the analog flags
    ch_sense_type [`NUM_CH-1:0] sense_m_q;
    ch_sense_type [`NUM_CH-1:0] sense_s_q;
    ch_sense_type [`NUM_CH-1:0] sense_p_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sense_m_q <= '0;
            sense_s_q <= '0;
            sense_p_q <= '0;
        end
        else
        begin
            sense_m_q <= sense;
            sense_s_q <= sense_m_q;
            sense_p_q <= sense_s_q;
        end
    end

    // classification with double-fault priority
    function automatic fault_type classify(input ch_sense_type s, input logic line,
                                           input logic allow_open);
        fault_type f;
        logic ld_short;
        logic ld_open;
        f = '0;
        ld_short = line ? s.load_short_line : s.load_short_spk;
        ld_open = line ? s.load_open_line : s.load_open_spk;
        if (s.gnd_short | s.vs_short)
        begin
            f.gnd = s.gnd_short;
            f.vs = s.vs_short;
        end
        else if (ld_short)
            f.across = 1'b1;
        else if (ld_open & allow_open)
            f.open = 1'b1;
        return f;
    endfunction : classify

    // turn-on pulse sequencer
    ton_state_type ton_q;
    ton_state_type ton_d;
    logic [`CNT_W-1:0] ton_cnt_q;
    logic ton_armed_q;
    logic hiz_q;
    logic pulse_q;
    wire ton_end = (ton_q == TON_PULSE) && (ton_cnt_q == DIAG_LAST);

    always_comb
    begin
        ton_d = ton_q;
        case (ton_q)
            TON_STBY:
                if (stby_rise)
                    ton_d = (pwdata[`C1_DIAG_EN] & ton_armed_q) ? TON_PULSE : TON_BIASED;
            TON_PULSE:
                if (wr_one & ~pwdata[`C1_STBY_OUT])
                    ton_d = TON_STBY;
                else if (ton_end)
                    ton_d = TON_BIASED;
            TON_BIASED:
                if (wr_one & ~pwdata[`C1_STBY_OUT])
                    ton_d = TON_STBY;
            default:
                ton_d = TON_STBY;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ton_q <= TON_STBY;
            ton_cnt_q <= '0;
            ton_armed_q <= 1'b1;
            hiz_q <= 1'b1;
            pulse_q <= 1'b0;
        end
        else
        begin
            ton_q <= ton_d;
            ton_cnt_q <= (ton_d == TON_PULSE && ton_q == TON_PULSE) ? ton_cnt_q + 1'b1 : '0;
            hiz_q <= (ton_d != TON_BIASED);
            pulse_q <= (ton_d == TON_PULSE);
            if (host_read)
                ton_armed_q <= 1'b1;
            else if (ton_end)
                ton_armed_q <= 1'b0;
        end
    end

    // per-channel permanent, offset and ac diagnostics
    result_type [`NUM_CH-1:0] cur_res;
    logic [`NUM_CH-1:0] on_w;
    logic [`NUM_CH-1:0] diag_busy_w;

    genvar ch;
    generate
        for (ch = 0; ch < `NUM_CH; ch++)
        begin : g_ch
            ch_state_type st_q;
            ch_state_type st_d;
            logic [`CNT_W-1:0] cnt_q;
            fault_type ton_res_q;
            fault_type perm_res_q;
            logic armed_q;
            logic done_q;
            logic off_ok_q;
            logic off_sus_q;
            logic ac_sus_q;
            logic [1:0] ac_cnt_q;

            wire ch_sense_type s = sense_s_q[ch];
            wire sc = s.sc_prot;
            wire biased = (ton_q == TON_BIASED);
            wire tick = (cnt_q == RECHECK_LAST);
            wire diag_end = (st_q == CH_DIAG) && (cnt_q == DIAG_LAST);
            wire fault_type perm_f = classify(s, line_mode, 1'b0);
            wire fault_type ton_f = classify(s, line_mode, 1'b1);
            wire ac_sel = ac_low_thr ? s.ac_pk_lo : s.ac_pk_hi;
            wire ac_prev = ac_low_thr ? sense_p_q[ch].ac_pk_lo : sense_p_q[ch].ac_pk_hi;
            wire ac_edge = ac_sel & ~ac_prev;
            wire off_start = host_read | offset_rise;

            always_comb
            begin
                st_d = st_q;
                case (st_q)
                    CH_ACTIVE:
                        if (biased & sc)
                            st_d = (diag_en & armed_q) ? CH_CHECK : CH_SHUT;
                    CH_CHECK:
                        if (tick)
                            st_d = sc ? CH_DIAG : CH_ACTIVE;
                    CH_DIAG:
                        if (diag_end)
                            st_d = CH_SHUT;
                    CH_SHUT:
                        if (tick & ~sc)
                            st_d = CH_ACTIVE;
                    default:
                        st_d = CH_ACTIVE;
                endcase
                if (!biased)
                    st_d = CH_ACTIVE;
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    st_q <= CH_ACTIVE;
                    cnt_q <= '0;
                    ton_res_q <= '0;
                    perm_res_q <= '0;
                    armed_q <= 1'b1;
                    done_q <= 1'b0;
                end
                else
                begin
                    st_q <= st_d;
                    if (st_d != st_q || st_q == CH_ACTIVE || (tick && st_q == CH_SHUT))
                        cnt_q <= '0;
                    else
                        cnt_q <= cnt_q + 1'b1;
                    if (ton_end)
                        ton_res_q <= ton_f;
                    else if (diag_end && perm_f != '0)
                        ton_res_q <= '0;
                    if (diag_end)
                        perm_res_q <= perm_f;
                    else if (host_read && st_q != CH_SHUT)
                        perm_res_q <= '0;
                    if (host_read)
                        armed_q <= 1'b1;
                    else if (diag_end)
                        armed_q <= 1'b0;
                    if (diag_end | ton_end)
                        done_q <= 1'b1;
                    else if (host_read)
                        done_q <= 1'b0;
                end
            end

            // offset window and ac pulse counting
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    off_ok_q <= 1'b0;
                    off_sus_q <= 1'b0;
                    ac_sus_q <= 1'b0;
                    ac_cnt_q <= 2'd0;
                end
                else
                begin
                    if (off_start)
                        off_ok_q <= 1'b1;
                    else if (!s.offset_high)
                        off_ok_q <= 1'b0;
                    if (off_start)
                        off_sus_q <= 1'b0;
                    else if (sc)
                        off_sus_q <= 1'b1;
                    if (host_read | ac_rise)
                        ac_sus_q <= 1'b0;
                    else if (sc & ac_en)
                        ac_sus_q <= 1'b1;
                    if (host_read | ac_rise)
                        ac_cnt_q <= 2'd0;
                    else if (ac_en & ~ac_sus_q & ac_edge & (ac_cnt_q != `AC_PULSES_MIN))
                        ac_cnt_q <= ac_cnt_q + 2'd1;
                end
            end

            assign cur_res[ch].fault = (perm_res_q != '0) ? perm_res_q : ton_res_q;
            assign cur_res[ch].offset_high = offset_en & off_ok_q & ~off_sus_q;
            assign cur_res[ch].tweeter_open = ac_en & ~ac_sus_q & (ac_cnt_q != `AC_PULSES_MIN);
            assign cur_res[ch].diag_done = done_q;
            assign cur_res[ch].spare = 1'b0;
            // stage follows the next turn-on state, so it never overlaps high impedance
            assign on_w[ch] = (ton_d == TON_BIASED) && (st_d == CH_ACTIVE);
            assign diag_busy_w[ch] = (st_q == CH_CHECK) || (st_q == CH_DIAG);
        end
    endgenerate

    // status: busy channels, off channels, turn-on state
    assign status_w = {20'h0_0000, diag_busy_w, ~on_w, 1'b0, ton_q};

    // results snapshot taken at each read; the read returns the earlier one
    logic [`NUM_CH-1:0] stage_on_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            report_q <= 32'h0000_0000;
            stage_on_q <= '0;
        end
        else
        begin
            if (host_read)
                report_q <= cur_res;
            stage_on_q <= on_w;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign stage_on = stage_on_q;
    assign stage_hiz = hiz_q;
    assign test_pulse_on = pulse_q;

endmodule : amp_output_fault_diagnostics
`default_nettype wire

// [sim/amp_output_fault_diagnostics_props.sv]
// concurrent checks on the ports of the diagnostics block
`timescale 1ns/1ps
`default_nettype none
module amp_output_fault_diagnostics_props #(
    parameter int DIAG_CYCLE_CYC = 50
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] stage_on,
    input wire logic stage_hiz,
    input wire logic test_pulse_on
);
    logic [31:0] cnt_q;
    wire mapped = paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0;
    wire arm_wr = psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[0] && pwdata[4];
    // length of the current test pulse so far
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= '0;
        else
            cnt_q <= test_pulse_on ? cnt_q + 32'h0000_0001 : '0;
    end
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_ready_once: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_map_err: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address map");
    a_err_zero: assert property (pready && (pslverr || pwrite) |-> prdata == 32'h0000_0000)
        else $error("prdata not zero on error or write");
    a_pulse_hiz: assert property (test_pulse_on |-> stage_hiz && stage_on == 4'h0)
        else $error("power stage on during test pulse");
    a_pulse_len: assert property ($fell(test_pulse_on) |-> cnt_q == DIAG_CYCLE_CYC)
        else $error("test pulse length wrong");
    a_pulse_cause: assert property ($rose(test_pulse_on) |-> $past(arm_wr) || $past(arm_wr, 2))
        else $error("test pulse without standby-out and enable write");
    a_on_not_hiz: assert property (stage_on != 4'h0 |-> !stage_hiz)
        else $error("channel on while outputs high impedance");
endmodule : amp_output_fault_diagnostics_props
bind amp_output_fault_diagnostics amp_output_fault_diagnostics_props #(
    .DIAG_CYCLE_CYC(DIAG_CYCLE_CYC)
) props_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stage_on(stage_on), .stage_hiz(stage_hiz), .test_pulse_on(test_pulse_on)
);
`default_nettype wire

// [sim/amp_load_model.sv]
// far-side load model: output faults and current peaks of a test tone
`timescale 1ns/1ps
`default_nettype none
module amp_load_model
    import diag_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire ch_sense_type [3:0] lvl,
    input wire logic [7:0] npk,
    input wire logic [3:0] mid_only,
    input wire logic go,
    output var ch_sense_type [3:0] sense
);
    logic [4:0] ph_q;
    logic [7:0] rem_q;
    logic [7:0] dec;
    // tone cycle of 25 clocks (125 ns), peak in the first 12
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ph_q <= 5'h00;
            rem_q <= 8'h00;
        end
        else if (go)
        begin
            ph_q <= 5'h00;
            rem_q <= npk;
        end
        else
        begin
            ph_q <= ph_q == 5'h18 ? 5'h00 : ph_q + 5'h01;
            if (ph_q == 5'h18)
                rem_q <= dec;
        end
    end
    // a large peak crosses both levels, a middling one the low only
    always_comb
    begin
        for (int c = 0; c < 4; c++)
        begin
            dec[2*c+:2] = rem_q[2*c+:2] == 2'h0 ? 2'h0 : rem_q[2*c+:2] - 2'h1;
            sense[c] = lvl[c];
            sense[c].ac_pk_lo = lvl[c].ac_pk_lo | (rem_q[2*c+:2] != 2'h0 && ph_q < 5'h0C);
            sense[c].ac_pk_hi = lvl[c].ac_pk_hi
                | (rem_q[2*c+:2] != 2'h0 && ph_q < 5'h0C && !mid_only[c]);
        end
    end
endmodule : amp_load_model
`default_nettype wire

// [sim/tb_amp_output_fault_diagnostics.sv]
// self-checking bench of the output fault diagnostics block
`timescale 1ns/1ps
`default_nettype none
`include "diag_cfg.svh"
module tb_amp_output_fault_diagnostics
    import diag_pkg::*;
;
    localparam int RCK = 20;
    localparam int DCY = 50;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic [7:0] paddr = 8'h00, npk = 8'h00;
    logic [3:0] mid_only = 4'h0;
    logic [31:0] pwdata = 32'h0000_0000;
    ch_sense_type [3:0] lvl = '0;
    ch_sense_type [3:0] sense;
    logic [31:0] prdata, q;
    logic pready, pslverr, e, stage_hiz, test_pulse_on;
    logic [3:0] stage_on;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    always #2.5 pclk = ~pclk;

    amp_output_fault_diagnostics #(.RECHECK_CYC(RCK), .DIAG_CYCLE_CYC(DCY))
    amp_output_fault_diagnostics_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sense(sense), .stage_on(stage_on), .stage_hiz(stage_hiz), .test_pulse_on(test_pulse_on)
    );
    amp_load_model amp_load_model_i (
        .pclk(pclk), .presetn(presetn), .lvl(lvl), .npk(npk), .mid_only(mid_only), .go(go),
        .sense(sense)
    );

    task complete_run;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            complete_run();
        end
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one apb transfer, entered and left just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        chk("pready", 32'(pready), 32'h0000_0001);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        xfer(1'b0, a, 32'h0000_0000);
        chk(nm, q & m, x);
    endtask : rdc

    task automatic waitv(input string nm, input bit sel, input logic [3:0] x, input int lim);
        logic [3:0] v;
        for (int n = 0; n < lim; n++)
        begin
            v = sel ? stage_on : {3'h0, test_pulse_on};
            if (v === x)
                break;
            @(posedge pclk);
        end
        chk(nm, 32'(v), 32'(x));
    endtask : waitv

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("idle", 32'({stage_hiz, test_pulse_on, stage_on}), 32'h0000_0020);
        rdc("ctrl one", `OFS_CTRL_ONE, 32'hFFFF_FFFF, `CTRL_ONE_RST);
        rdc("ctrl two", `OFS_CTRL_TWO, 32'hFFFF_FFFF, `CTRL_TWO_RST);
        xfer(1'b1, 8'h10, 32'hFFFF_FFFF);
        chk("unmapped", 32'(e), 32'h0000_0001);
        xfer(1'b1, `OFS_RESULT, 32'hFFFF_FFFF);
        // low gain with line diagnostic: line load flags count
        xfer(1'b1, `OFS_CTRL_TWO, 32'h0000_0003);
        lvl <= {10'h010, 10'h060, 10'h300, 10'h210};
        xfer(1'b1, `OFS_CTRL_ONE, 32'h0000_0011);
        waitv("pulse on", 1'b0, 4'h1, 10);
        chk("pulse hiz", 32'({stage_hiz, stage_on}), 32'h0000_0010);
        waitv("pulse end", 1'b0, 4'h0, DCY + 10);
        waitv("biased", 1'b1, 4'hF, 10);
        rdc("first read", `OFS_RESULT, 32'hFFFF_FFFF, 32'h0000_0000);
        lvl <= '0;
        rdc("turn-on", `OFS_RESULT, 32'hFFFF_FFFF, 32'h4142_4C48);
        rdc("held", `OFS_RESULT, 32'hBFBF_BFBF, 32'h0102_0C08);
        lvl <= {20'h0_0000, 10'h000, 10'h118};
        waitv("shut", 1'b1, 4'hE, RCK + DCY + 20);
        repeat (RCK + DCY + 10) @(posedge pclk);
        rdc("status", `OFS_STATUS, 32'h0000_0FFF, 32'h0000_0014);
        xfer(1'b0, `OFS_RESULT, 32'h0000_0000);
        lvl <= '0;
        rdc("perm", `OFS_RESULT, 32'h0000_00FF, 32'h0000_0044);
        waitv("restart", 1'b1, 4'hF, 2 * RCK + 10);
        xfer(1'b1, `OFS_CTRL_ONE, 32'h0000_0001);
        lvl <= {20'h0_0000, 10'h008, 10'h000};
        waitv("ch1 off", 1'b1, 4'hD, 10);
        repeat (3 * RCK) @(posedge pclk);
        chk("still off", 32'(stage_on), 32'h0000_000D);
        lvl <= '0;
        waitv("ch1 back", 1'b1, 4'hF, RCK + 10);
        // quiet outputs, no tone while the offset window runs
        lvl <= {10'h00C, 10'h004, 10'h004, 10'h000};
        repeat (4) @(posedge pclk);
        xfer(1'b1, `OFS_CTRL_ONE, 32'h0000_0031);
        lvl <= {10'h004, 10'h004, 10'h000, 10'h000};
        repeat (4) @(posedge pclk);
        lvl <= {10'h004, 10'h004, 10'h004, 10'h000};
        repeat (30) @(posedge pclk);
        xfer(1'b0, `OFS_RESULT, 32'h0000_0000);
        rdc("offset", `OFS_RESULT, 32'h1010_1010, 32'h0010_0000);
        rdc("offset next", `OFS_RESULT, 32'h1010_1010, 32'h1010_1000);
        lvl <= '0;
        xfer(1'b1, `OFS_CTRL_ONE, 32'h0000_0011);
        for (int t = 0; t < 2; t++)
        begin
            xfer(1'b1, `OFS_CTRL_TWO, t == 0 ? 32'h0000_0004 : 32'h0000_0084);
            xfer(1'b0, `OFS_RESULT, 32'h0000_0000);
            npk <= 8'hFB;
            mid_only <= 4'h4;
            lvl <= t == 1 ? {20'h0_0000, 10'h008, 10'h000} : '0;
            go <= 1'b1;
            @(posedge pclk);
            go <= 1'b0;
            repeat (3) @(posedge pclk);
            lvl <= '0;
            repeat (90) @(posedge pclk);
            xfer(1'b0, `OFS_RESULT, 32'h0000_0000);
            rdc("tweeter", `OFS_RESULT, 32'h2020_2020, t == 0 ? 32'h0020_2000 : 32'h0);
        end
        complete_run();
    end
endmodule : tb_amp_output_fault_diagnostics
`default_nettype wire
